// File: rtl/abd_prescaler.sv
module abd_prescaler
  import uart_abd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [4:0] shiftSel,
  output logic            tick
);

  // divider count and tick
  typedef struct packed {
    logic [8:0] count;  // oscillator cycles in this period
    logic       tick;   // one cycle pulse per period
  } pre_state_type;

  pre_state_type r;
  pre_state_type n;
  logic [9:0]    span;  // period length, up to 512

  // restarts while stopped so the first period is whole
  always_comb
  begin
    n = r;
    span = 10'h001 << shiftSel;
    n.tick = 1'b0;
    if (!run)
    begin
      n.count = '0;
    end
    else if (r.count == 9'(span - 10'h001))
    begin
      n.count = '0;
      n.tick = 1'b1;
    end
    else
    begin
      n.count = r.count + 9'h001;
    end
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign tick = r.tick;

endmodule : abd_prescaler

// File: rtl/rx_line_sync.sv
module rx_line_sync
  import uart_abd_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic lineIn,
  output logic      lineOut
);

  // three stage chain plus the accepted level
  typedef struct packed {
    logic s1;     // metastability catcher, read by s2 only
    logic s2;     // second stage
    logic s3;     // third stage
    logic level;  // accepted line level
  } sync_state_type;

  sync_state_type r;
  sync_state_type n;

  // level changes only when stages two and three agree
  always_comb
  begin
    n = r;
    n.s1 = lineIn;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3)
    begin
      n.level = r.s3;
    end
  end

  // idle line is high, so reset to high
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r <= '1;
    end
    else
    begin
      r <= n;
    end
  end

  assign lineOut = r.level;

endmodule : rx_line_sync

// File: rtl/uart_abd_pkg.sv
// Behaviour
// - measure received 55h sync on receive line
// - enable starts calibration, receiver held idle
// - counting starts at first rise after start
// - fifth rise stores count, clears enable, flags
// - receive data read clears receive flag
// - both divisor bytes form one 16-bit counter
// - counter advances at base rate over eight
// - measure clock osc over 32, 128, 512
// - counter starts at one; software subtracts one
// - with wake enable, measure character after break
// - overflow sets flag, counting continues to fifth
// - overflow clear ignored while enable still set
// - wake on break only in asynchronous mode
// - wake enable idles receiver, watches falling edge
// - wake event raises receive flag; read clears
// - rising edge ending break clears wake enable
// - nonzero character: first low time wakes
package uart_abd_pkg;

  // register byte addresses on the bus
  localparam logic [31:0] BAUD_CONTROL_ADDR = 32'h0000_0000;
  localparam logic [31:0] DIVISOR_LOW_ADDR  = 32'h0000_0004;
  localparam logic [31:0] DIVISOR_HIGH_ADDR = 32'h0000_0008;
  localparam logic [31:0] RECEIVE_DATA_ADDR = 32'h0000_000C;
  localparam logic [31:0] RX_STATUS_ADDR    = 32'h0000_0010;

  // baud control field positions
  localparam int CTL_AUTOBAUD   = 0;
  localparam int CTL_OVERFLOW   = 1;
  localparam int CTL_WAKE       = 2;
  localparam int CTL_DIV16      = 3;
  localparam int CTL_HIGH_SPEED = 4;
  localparam int CTL_SYNC_MODE  = 5;
  localparam int CTL_RX_IDLE    = 6;

  // receive status field positions
  localparam int STAT_RX_FLAG  = 0;
  localparam int STAT_FRAMING  = 1;
  localparam int STAT_OVERRUN  = 2;

  // reset values
  localparam logic [7:0]  BAUD_CONTROL_RESET = 8'h00;
  localparam logic [7:0]  DIVISOR_RESET      = 8'h00;
  localparam logic [7:0]  RX_DATA_RESET      = 8'h00;
  localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

  // measurement constants
  localparam logic [15:0] ABD_START_COUNT = 16'h0001;
  localparam logic [15:0] ABD_MAX_COUNT   = 16'hFFFF;
  localparam logic [2:0]  ABD_EDGES       = 3'h5;

  // base clock as a power of two of the oscillator
  localparam logic [4:0] BASE_SHIFT_FAST = 5'h02;
  localparam logic [4:0] BASE_SHIFT_MID  = 5'h04;
  localparam logic [4:0] BASE_SHIFT_SLOW = 5'h06;
  // measuring clock runs eight times slower
  localparam logic [4:0] ABD_EXTRA_SHIFT = 5'h03;

  // character framing
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // measuring sequence
  typedef enum logic [1:0] {
    ABD_OFF,
    ABD_WAIT_START,
    ABD_WAIT_EDGE1,
    ABD_COUNT
  } abd_state_type;

  // receiver sequence
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_type;

endpackage : uart_abd_pkg

// File: rtl/uart_autobaud_wake.sv
// Our own choices: the AHB-Lite register port and the placing of the registers.
module uart_autobaud_wake
  import uart_abd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // line and system side
  input  wire logic        receive_line,
  input  wire logic        sleepMode,
  output logic             wakeRequest,
  output logic             bitRateTick
);

  // whole block state
  typedef struct packed {
    // baud control
    logic          autobaudEnable;
    logic          overflowFlag;
    logic          wakeEnable;
    logic          div16Select;
    logic          highSpeedSelect;
    logic          syncMode;
    // divisor pair, also the measuring counter
    logic [7:0]    divisorLow;
    logic [7:0]    divisorHigh;
    // receive side
    logic [7:0]    rxData;
    logic          rxFlag;
    logic          framingErr;
    logic          overrunErr;
    rx_state_type  rxState;
    logic [23:0]   rxTimer;
    logic [2:0]    bitIdx;
    logic [7:0]    shiftReg;
    logic          rxPrev;
    // measuring and wake
    abd_state_type abdState;
    logic [2:0]    edgeCount;
    logic          wakeLow;
    logic          wakeRequest;
    // transmit bit rate
    logic [23:0]   txTimer;
    logic          bitRateTick;
    // bus data phase
    logic          dataPhase;
    logic          dWrite;
    logic [31:0]   dAddr;
    logic [31:0]   hrdata;
    logic          readyOut;  // data phase never stretched
    logic          respErr;   // error response never given
  } state_type;

  state_type   r;
  state_type   n;
  logic        rxLine;     // filtered receive line
  logic        abdTick;    // measuring clock pulse
  logic [4:0]  baseShift;  // base clock power of two
  logic [15:0] divisor;    // divisor in use
  logic [23:0] period;     // bit time in oscillator cycles
  logic        rxFall;     // line went low
  logic        rxRise;     // line went high
  logic        rxAllowed;  // normal reception permitted
  logic        addrPhase;  // transfer taken this edge
  logic [15:0] abdNext;    // counter plus one

  // receive pin crosses in through four flops
  rx_line_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .lineIn  (receive_line),
    .lineOut (rxLine)
  );

  // measuring clock, eight base periods
  abd_prescaler u_pre (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .run      (r.abdState == ABD_COUNT),
    .shiftSel (5'(baseShift + ABD_EXTRA_SHIFT)),
    .tick     (abdTick)
  );

  // base clock choice from the two speed bits
  assign baseShift = (r.div16Select && r.highSpeedSelect) ? BASE_SHIFT_FAST
                   : (r.div16Select || r.highSpeedSelect) ? BASE_SHIFT_MID
                   : BASE_SHIFT_SLOW;

  // bit time is base times divisor plus one
  assign divisor = r.div16Select ? {r.divisorHigh, r.divisorLow}
                                 : {8'h00, r.divisorLow};
  assign period  = ({8'h00, divisor} + 24'h00_0001) << baseShift;
  assign rxFall  = r.rxPrev && !rxLine;
  assign rxRise  = !r.rxPrev && rxLine;
  // neither measuring nor waking may receive characters
  assign rxAllowed = !r.autobaudEnable && !r.wakeEnable
                     && !r.syncMode;
  assign addrPhase = hsel && htrans[1] && hready;
  assign abdNext   = {r.divisorHigh, r.divisorLow} + 16'h0001;

  // next state: bus write, bus read, then hardware events
  always_comb
  begin
    n = r;
    n.rxPrev = rxLine;
    n.bitRateTick = 1'b0;
    n.readyOut = 1'b1;

    // data phase of a write lands here
    if (r.dataPhase && r.dWrite)
    begin
      unique case (r.dAddr)
        BAUD_CONTROL_ADDR:
        begin
          n.autobaudEnable  = hwdata[CTL_AUTOBAUD];
          n.div16Select     = hwdata[CTL_DIV16];
          n.highSpeedSelect = hwdata[CTL_HIGH_SPEED];
          n.syncMode        = hwdata[CTL_SYNC_MODE];
          // wake only offered in asynchronous mode
          n.wakeEnable = hwdata[CTL_WAKE]
                         && !hwdata[CTL_SYNC_MODE];
          // clear only once enable was already off
          if (!hwdata[CTL_OVERFLOW] && !r.autobaudEnable)
          begin
            n.overflowFlag = 1'b0;
          end
        end
        DIVISOR_LOW_ADDR:  n.divisorLow = hwdata[7:0];
        DIVISOR_HIGH_ADDR: n.divisorHigh = hwdata[7:0];
        // read-only or unmapped: ignored
        default: ;
      endcase
    end

    // read value sees this cycle's write
    n.hrdata = READ_ZERO;
    if (addrPhase && !hwrite)
    begin
      unique case (haddr)
        BAUD_CONTROL_ADDR:
        begin
          n.hrdata[CTL_AUTOBAUD]   = n.autobaudEnable;
          n.hrdata[CTL_OVERFLOW]   = n.overflowFlag;
          n.hrdata[CTL_WAKE]       = n.wakeEnable;
          n.hrdata[CTL_DIV16]      = n.div16Select;
          n.hrdata[CTL_HIGH_SPEED] = n.highSpeedSelect;
          n.hrdata[CTL_SYNC_MODE]  = n.syncMode;
          n.hrdata[CTL_RX_IDLE]    = (r.rxState == RX_IDLE);
        end
        DIVISOR_LOW_ADDR:  n.hrdata[7:0] = n.divisorLow;
        DIVISOR_HIGH_ADDR: n.hrdata[7:0] = n.divisorHigh;
        RECEIVE_DATA_ADDR:
        begin
          n.hrdata[7:0] = r.rxData;
          // reading the data acknowledges the flag
          n.rxFlag = 1'b0;
          n.overrunErr = 1'b0;
        end
        RX_STATUS_ADDR:
        begin
          n.hrdata[STAT_RX_FLAG] = r.rxFlag;
          n.hrdata[STAT_FRAMING] = r.framingErr;
          n.hrdata[STAT_OVERRUN] = r.overrunErr;
        end
        // unmapped reads as zero
        default: ;
      endcase
    end

    // bus phase tracking; slave never stalls
    if (hready)
    begin
      n.dataPhase = addrPhase;
      n.dWrite = hwrite;
      n.dAddr = haddr;
    end

    // transmit bit rate generator, frozen while measuring
    if (r.autobaudEnable || r.txTimer >= period - 24'h00_0001)
    begin
      n.txTimer = '0;
      n.bitRateTick = !r.autobaudEnable;
    end
    else
      n.txTimer = r.txTimer + 24'h00_0001;

    // wake on break watcher
    if (r.wakeEnable)
    begin
      if (rxFall && !r.wakeLow)
      begin
        // any falling edge is the wake event
        n.wakeLow = 1'b1;
        n.rxFlag = 1'b1;
        n.wakeRequest = sleepMode;
      end
      else if (rxRise && r.wakeLow)
      begin
        // first rise ends the break, even mid-character
        n.wakeLow = 1'b0;
        n.wakeEnable = 1'b0;
      end
    end
    else
      n.wakeLow = 1'b0;
    if (!sleepMode)
      n.wakeRequest = 1'b0;

    // rate measurement; waits out any pending break
    if (!r.autobaudEnable)
      n.abdState = ABD_OFF;
    else
    begin
      unique case (r.abdState)
        ABD_OFF:
        begin
          if (!r.wakeEnable)
            n.abdState = ABD_WAIT_START;
        end
        ABD_WAIT_START:
        begin
          if (rxFall)
            n.abdState = ABD_WAIT_EDGE1;
        end
        ABD_WAIT_EDGE1:
        begin
          if (rxRise)
          begin
            // counter seeded with one at the first rise
            {n.divisorHigh, n.divisorLow} = ABD_START_COUNT;
            n.edgeCount = 3'h1;
            n.abdState = ABD_COUNT;
          end
        end
        ABD_COUNT:
        begin
          if (abdTick)
          begin
            // both bytes count as one 16-bit word
            {n.divisorHigh, n.divisorLow} = abdNext;
            if ({r.divisorHigh, r.divisorLow} == ABD_MAX_COUNT)
              n.overflowFlag = 1'b1;
          end
          if (rxRise)
          begin
            n.edgeCount = r.edgeCount + 3'h1;
            if (r.edgeCount + 3'h1 == ABD_EDGES)
            begin
              // count stays in the divisor pair
              n.autobaudEnable = 1'b0;
              n.rxFlag = 1'b1;
              n.abdState = ABD_OFF;
            end
          end
        end
      endcase
    end
    // flag holds while the measurement is enabled
    if (n.autobaudEnable && r.overflowFlag)
      n.overflowFlag = 1'b1;

    // character receiver, sampling at mid bit
    if (!rxAllowed)
      n.rxState = RX_IDLE;
    else
    begin
      unique case (r.rxState)
        RX_IDLE:
        begin
          n.rxTimer = '0;
          if (rxFall)
            n.rxState = RX_START;
        end
        RX_START:
        begin
          n.rxTimer = r.rxTimer + 24'h00_0001;
          if (r.rxTimer == (period >> 1))
          begin
            // glitch shorter than half a bit is dropped
            n.rxTimer = '0;
            n.bitIdx = '0;
            n.rxState = rxLine ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          n.rxTimer = r.rxTimer + 24'h00_0001;
          if (r.rxTimer == period - 24'h00_0001)
          begin
            n.rxTimer = '0;
            n.shiftReg = {rxLine, r.shiftReg[7:1]};
            n.bitIdx = r.bitIdx + 3'h1;
            if (r.bitIdx == LAST_DATA_BIT)
              n.rxState = RX_STOP;
          end
        end
        RX_STOP:
        begin
          n.rxTimer = r.rxTimer + 24'h00_0001;
          if (r.rxTimer == period - 24'h00_0001)
          begin
            // unread character is kept; new one lost
            n.rxState = RX_IDLE;
            n.framingErr = !rxLine;
            if (r.rxFlag)
            begin
              n.overrunErr = 1'b1;
            end
            else
            begin
              n.rxData = r.shiftReg;
              n.rxFlag = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.divisorLow <= DIVISOR_RESET;
      r.divisorHigh <= DIVISOR_RESET;
      r.rxData <= RX_DATA_RESET;
      r.rxState <= RX_IDLE;
      r.abdState <= ABD_OFF;
      r.rxPrev <= 1'b1;
      r.readyOut <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // outputs straight from flops; zero wait, always okay
  assign hreadyout   = r.readyOut;
  assign hresp       = r.respErr;
  assign hrdata      = r.hrdata;
  assign wakeRequest = r.wakeRequest;
  assign bitRateTick = r.bitRateTick;

endmodule : uart_autobaud_wake

// File: test/remote_transmitter.sv
module remote_transmitter
(
  input  wire logic ref_clk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle high, as the pull-up leaves it between frames
  initial line = 1'b1;
  // one level held for a number of cycles
  task automatic hold(input logic lvl, input int cycles);
    @(posedge ref_clk);
    line <= lvl;
    repeat (cycles - 1) @(posedge ref_clk);
  endtask : hold
  // start, eight bits lsb first, stop
  task automatic send_char(input logic [7:0] b, input int bitT);
    hold(1'b0, bitT);
    for (int i = 0; i < 8; i++)
      hold(b[i], bitT);
    hold(1'b1, bitT);
  endtask : send_char
  // all-zero wake character, long form for lin
  task automatic send_break(input int bitT);
    hold(1'b0, 13 * bitT);
    hold(1'b1, bitT);
  endtask : send_break
endmodule : remote_transmitter

// File: test/testbench.sv
`define CHECK(act, exp) \
  begin \
    n_checks++; \
    if ((act) !== (exp)) \
    begin \
      errors++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, act, exp); \
    end \
  end
module testbench
  import uart_abd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] mask; // bits that matter
    logic [31:0] lo;   // lowest accepted value
    logic [31:0] hi;   // highest accepted value
  } expect_type;
  logic        ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        receive_line, sleepMode, wakeRequest, bitRateTick;
  logic [31:0] haddr, hwdata, hrdata, got, want;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        rdPhase;       // a read data phase is running
  expect_type  expQ[$];       // notes from the driver
  expect_type  e;             // note being judged
  int          errors, n_checks, k, d, bitT, ex;
  int          spd[4] = '{3, 2, 1, 0};        // speed bit pairs
  int          bits[4] = '{160, 320, 320, 1024}; // bit times
  // bus hready is our only slave's hreadyout
  assign hready = hreadyout;
  uart_autobaud_wake uart_autobaud_wake_inst (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .receive_line(receive_line),
    .sleepMode(sleepMode), .wakeRequest(wakeRequest),
    .bitRateTick(bitRateTick));
  remote_transmitter remote_transmitter_inst (
    .ref_clk(ref_clk), .line(receive_line));
  // 40 mhz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // judge read data at the edge that ends its data phase
  always @(posedge ref_clk)
  begin
    if (rdPhase === 1'b1 && expQ.size() > 0)
    begin
      e = expQ.pop_front();
      got = hrdata & e.mask;
      // a value inside the window counts as exact
      want = (^got !== 1'bx && got >= e.lo && got <= e.hi) ? got : e.lo;
      `CHECK(got, want)
    end
    rdPhase <= ~rst & hsel & htrans[1] & hready & ~hwrite;
  end
  // hang guard, well above the expected run
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
  task automatic wait_ready();
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
  endtask : wait_ready
  // one transfer; entered just after a clock edge
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] dat);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= dat;
    wait_ready();
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] dat);
    xfer(a, 1'b1, dat);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] m,
                    input logic [31:0] lo, input logic [31:0] hi);
    expQ.push_back('{m, lo, hi});
    xfer(a, 1'b0, 32'h0000_0000);
  endtask : rd
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // main sequence
  initial
  begin
    {hsel, hwrite, htrans, sleepMode} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'b010;
    rst = 1'b1;
    errors = 0;
    n_checks = 0;
    void'($urandom(32'h6e39_bdb4));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values; receiver idle bit left out
    rd(BAUD_CONTROL_ADDR, 32'h0000_003F, 0, 0);
    for (int a = 4; a <= 20; a += 4)
      rd(a, 32'hFFFF_FFFF, 0, 0);
    wr(RX_STATUS_ADDR, 32'h0000_0007);
    rd(RX_STATUS_ADDR, 32'hFFFF_FFFF, 0, 0);
    d = $urandom_range(0, 255);
    wr(DIVISOR_LOW_ADDR, d);
    wr(DIVISOR_HIGH_ADDR, 255 - d);
    rd(DIVISOR_LOW_ADDR, 32'hFFFF_FFFF, d, d);
    rd(DIVISOR_HIGH_ADDR, 32'hFFFF_FFFF, 255 - d, 255 - d);
    done("registers");
    // measure a sync character in every speed setting
    for (int i = 0; i < 4; i++)
    begin
      ex = 1 + 8 * bits[i] / (spd[i] == 3 ? 32 : spd[i] == 0 ? 512 : 128);
      wr(BAUD_CONTROL_ADDR, spd[i] * 8 + 1);
      remote_transmitter_inst.send_char(8'h55, bits[i]);
      repeat (8) @(posedge ref_clk);
      rd(DIVISOR_LOW_ADDR, 32'h0000_00FF, ex - 1, ex);
      rd(DIVISOR_HIGH_ADDR, 32'h0000_00FF, 0, 0);
      rd(BAUD_CONTROL_ADDR, 32'h0000_0001, 0, 0);
      rd(RX_STATUS_ADDR, 32'h0000_0007, 1, 1);
      rd(RECEIVE_DATA_ADDR, 32'h0000_00FF, 0, 0);
      rd(RX_STATUS_ADDR, 32'h0000_0001, 0, 0);
    end
    done("autobaud");
    // wake from sleep on a break, then measure the sync
    sleepMode <= 1'b1;
    wr(BAUD_CONTROL_ADDR, 32'h0000_001D);
    fork
      remote_transmitter_inst.send_break(160);
      begin
        repeat (200) @(posedge ref_clk);
        #1 `CHECK(wakeRequest, 1'b1)
        @(posedge ref_clk);
        rd(RX_STATUS_ADDR, 32'h0000_0001, 1, 1);
        rd(BAUD_CONTROL_ADDR, 32'h0000_0005, 5, 5);
        rd(RECEIVE_DATA_ADDR, 32'h0000_00FF, 0, 0);
        rd(RX_STATUS_ADDR, 32'h0000_0001, 0, 0);
      end
    join
    sleepMode <= 1'b0;
    rd(BAUD_CONTROL_ADDR, 32'h0000_0005, 1, 1);
    remote_transmitter_inst.send_char(8'h55, 160);
    repeat (8) @(posedge ref_clk);
    rd(DIVISOR_LOW_ADDR, 32'h0000_00FF, 40, 41);
    rd(BAUD_CONTROL_ADDR, 32'h0000_0001, 0, 0);
    rd(RECEIVE_DATA_ADDR, 32'h0000_00FF, 0, 0);
    done("wake");
    // wake refused in sync mode; abort by enable then flag
    wr(BAUD_CONTROL_ADDR, 32'h0000_0024);
    rd(BAUD_CONTROL_ADDR, 32'h0000_003F, 32'h20, 32'h20);
    wr(BAUD_CONTROL_ADDR, 32'h0000_0019);
    remote_transmitter_inst.hold(1'b0, 160);
    remote_transmitter_inst.hold(1'b1, 40);
    // push the running counter to its top; twice each beats a tick
    for (int j = 0; j < 4; j++)
      wr(j < 2 ? DIVISOR_HIGH_ADDR : DIVISOR_LOW_ADDR, 32'h0000_00FF);
    repeat (40) @(posedge ref_clk);
    rd(BAUD_CONTROL_ADDR, 32'h0000_0003, 3, 3);
    wr(BAUD_CONTROL_ADDR, 32'h0000_0019);
    rd(BAUD_CONTROL_ADDR, 32'h0000_0003, 3, 3);
    wr(BAUD_CONTROL_ADDR, 32'h0000_0000);
    rd(BAUD_CONTROL_ADDR, 32'h0000_0003, 2, 2);
    wr(BAUD_CONTROL_ADDR, 32'h0000_0000);
    rd(BAUD_CONTROL_ADDR, 32'h0000_0003, 0, 0);
    rd(RX_STATUS_ADDR, 32'h0000_0001, 0, 0);
    done("abort");
    // fast mode bit rate period
    d = $urandom_range(0, 7);
    wr(DIVISOR_LOW_ADDR, d);
    wr(DIVISOR_HIGH_ADDR, 0);
    wr(BAUD_CONTROL_ADDR, 32'h0000_0018);
    k = 0;
    while (bitRateTick !== 1'b1 && k < 200)
    begin
      @(posedge ref_clk);
      #1 k++;
    end
    k = 0;
    do
    begin
      @(posedge ref_clk);
      #1 k++;
    end
    while (bitRateTick !== 1'b1 && k < 200);
    `CHECK(k, 4 * (d + 1))
    @(posedge ref_clk);
    done("rate");
    // a nonzero character wakes at its first low time
    wr(BAUD_CONTROL_ADDR, 32'h0000_0004);
    remote_transmitter_inst.send_char(8'hF0, 160);
    repeat (8) @(posedge ref_clk);
    rd(BAUD_CONTROL_ADDR, 32'h0000_0004, 0, 0);
    rd(RX_STATUS_ADDR, 32'h0000_0001, 1, 1);
    rd(RECEIVE_DATA_ADDR, 32'h0000_00FF, 0, 0);
    done("fragment");
    end_of_test();
  end
endmodule : testbench

// File: test/uart_abd_checker.sv
module uart_abd_checker
  import uart_abd_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        receive_line,
  input wire logic        sleepMode,
  input wire logic        wakeRequest,
  input wire logic        bitRateTick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        rdTaken_r; // read taken at the last edge
  logic [31:0] rdAddr_r;  // address of that read
  logic        mapped;    // that address hits a register
  // follow read data phases; reset folds into the term
  always_ff @(posedge ref_clk)
  begin
    rdTaken_r <= ~rst & hsel & htrans[1] & hready & ~hwrite;
    rdAddr_r  <= haddr;
  end
  assign mapped = rdAddr_r inside {BAUD_CONTROL_ADDR, DIVISOR_LOW_ADDR,
    DIVISOR_HIGH_ADDR, RECEIVE_DATA_ADDR, RX_STATUS_ADDR};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // slave never stretches a transfer
  property p_ready;
    hreadyout == 1'b1;
  endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  // response is always okay
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  // read data stands one cycle only
  property p_idle_zero;
    !rdTaken_r |-> hrdata == READ_ZERO;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("stale hrdata");
  // unmapped addresses read as zero
  property p_unmapped;
    rdTaken_r && !mapped |-> hrdata == READ_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
  // registers are one byte wide
  property p_upper_zero;
    rdTaken_r |-> hrdata[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits");
  // wake request only raised while asleep
  property p_wake_sleep;
    $rose(wakeRequest) |-> $past(sleepMode);
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake awake");
  // request drops once the system runs
  property p_wake_awake;
    !sleepMode |=> !wakeRequest;
  endproperty
  a_wake_awake: assert property (p_wake_awake) else $error("wake held");
  // only a low line can cause the wake
  property p_wake_edge;
    $rose(wakeRequest) |-> !$past(receive_line, 2);
  endproperty
  a_wake_edge: assert property (p_wake_edge) else $error("wake no fall");
  // shortest rate period is four cycles
  property p_tick_gap;
    bitRateTick |=> !bitRateTick [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too close");
endmodule : uart_abd_checker

bind uart_autobaud_wake uart_abd_checker uart_abd_checker_inst (
  .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .receive_line(receive_line), .sleepMode(sleepMode),
  .wakeRequest(wakeRequest), .bitRateTick(bitRateTick));
